// ===== hdl/motor_cfg_pkg.sv
// Purpose: Constants for the write-only motor drive configuration bank.
// Assumes: 40 MHz core clock; byte-wide host parallel port, 128-byte map.
// Notes: Two-byte fields store the low byte at the lower offset.
// Overview of operation
// [RULE_01] Carrier period is two times (period value plus one) clock cycles.
// [RULE_02] Alignment bit 0 gives asymmetrical, 1 symmetrical center-aligned PWM.
// [RULE_03] Mode bit 0 selects three-phase, 1 two-phase space vector modulation.
// [RULE_04] Variant bit picks two-phase type 1 or 2; ignored in three-phase mode.
// [RULE_05] Complementary gate transitions are separated by dead time clock cycles.
// [RULE_06] Upper and lower gates are active high when polarity bit is 1.
// [RULE_07] Brake output is active low for polarity 0, active high for 1.
// [RULE_08] Sync output is active low for polarity 0, active high for 1.
// [RULE_09] Kill input counts as asserted when it equals its polarity bit.
// [RULE_10] Written shutdown bit drives the gate driver shutdown output.
// [RULE_11] Three-phase mode keeps edges out of a guard band of 30 ns units.
// [RULE_12] Host programs modulator scale as period times root three times 4096/2355.
// [RULE_13] Feedback scale is signed 15-bit with 10 fraction bits, multiplies current.
// [RULE_14] Leg-shunt mode waits programmed seconds after stop, then restarts offset measure.
// [RULE_15] Direction bit 0 means reverse rotation, 1 means forward rotation.
// [RULE_16] Run bit written 1 starts the motor, written 0 stops it.
// [RULE_17] Emergency stop bit set forces an immediate coast stop.
// [RULE_18] Current gains: proportional 14 fraction bits, integral 19 fraction bits.
// [RULE_19] Quadrature and direct voltage outputs are clamped to their 16-bit limits.
// [RULE_20] Speed gains: proportional 5 fraction bits, integral 13 fraction bits.
// [RULE_21] Speed output limited to motoring limit above, regeneration limit below.
// [RULE_22] Start-up current is limited to the start-up limit, 4095 rated.
// [RULE_23] Internal address increments after every data byte read or written.
// [RULE_24] Low byte at lower offset, high byte next; bank is write-only.
package motor_cfg_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int GUARD_UNIT_NS = 30;
	localparam int SECOND_NS = 1000000000;
	localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	localparam int ADDR_W = 7;
	localparam int PERIOD_W = 13;
	localparam int FEEDBACK_FRAC_BITS = 10;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	// Register offsets
	localparam logic [6:0] OFS_GATE_CTRL = 7'h0C;
	localparam logic [6:0] OFS_PERIOD_LO = 7'h0D;
	localparam logic [6:0] OFS_MODE_PERIOD_HI = 7'h0E;
	localparam logic [6:0] OFS_DEAD_TIME = 7'h0F;
	localparam logic [6:0] OFS_FB_SCALE_LO = 7'h15;
	localparam logic [6:0] OFS_FB_SCALE_HI = 7'h16;
	localparam logic [6:0] OFS_RUN_CMD = 7'h17;
	localparam logic [6:0] OFS_START_LIM_LO = 7'h18;
	localparam logic [6:0] OFS_START_LIM_HI = 7'h19;
	localparam logic [6:0] OFS_CUR_KP_LO = 7'h1A;
	localparam logic [6:0] OFS_CUR_KP_HI = 7'h1B;
	localparam logic [6:0] OFS_CUR_KI_LO = 7'h1C;
	localparam logic [6:0] OFS_CUR_KI_HI = 7'h1D;
	localparam logic [6:0] OFS_VQ_LIM_LO = 7'h22;
	localparam logic [6:0] OFS_VQ_LIM_HI = 7'h23;
	localparam logic [6:0] OFS_VD_LIM_LO = 7'h26;
	localparam logic [6:0] OFS_VD_LIM_HI = 7'h27;
	localparam logic [6:0] OFS_SPD_KP_LO = 7'h32;
	localparam logic [6:0] OFS_SPD_KP_HI = 7'h33;
	localparam logic [6:0] OFS_SPD_KI_LO = 7'h34;
	localparam logic [6:0] OFS_SPD_KI_HI = 7'h35;
	localparam logic [6:0] OFS_MOTOR_LIM_LO = 7'h36;
	localparam logic [6:0] OFS_MOTOR_LIM_HI = 7'h37;
	localparam logic [6:0] OFS_REGEN_LIM_LO = 7'h38;
	localparam logic [6:0] OFS_REGEN_LIM_HI = 7'h39;
	localparam logic [6:0] OFS_SPD_SCALE_LO = 7'h3A;
	localparam logic [6:0] OFS_SPD_SCALE_HI = 7'h3B;
	localparam logic [6:0] OFS_SPD_SET_LO = 7'h3C;
	localparam logic [6:0] OFS_SPD_SET_HI = 7'h3D;
	localparam logic [6:0] OFS_ACCEL = 7'h3E;
	localparam logic [6:0] OFS_DECEL = 7'h3F;
	localparam logic [6:0] OFS_MOD_SCALE_LO = 7'h44;
	localparam logic [6:0] OFS_MOD_SCALE_HI = 7'h45;
	localparam logic [6:0] OFS_GUARD = 7'h51;
	localparam logic [6:0] OFS_MIN_SPEED = 7'h7A;
	localparam logic [6:0] OFS_OFFSET_DELAY = 7'h7D;
	// Field positions
	localparam int BIT_KILL_POL = 7;
	localparam int BIT_LOWER_POL = 5;
	localparam int BIT_UPPER_POL = 4;
	localparam int BIT_SYNC_POL = 3;
	localparam int BIT_BRAKE_POL = 2;
	localparam int BIT_SHUTDOWN = 1;
	localparam int BIT_MOD_SELECT = 7;
	localparam int BIT_TWO_PH_VARIANT = 6;
	localparam int BIT_ALIGNMENT = 5;
	localparam int BIT_ESTOP = 2;
	localparam int BIT_RUN = 1;
	localparam int BIT_DIRECTION = 0;
endpackage

// ===== hdl/motor_drive_write_config_bank.sv
// Purpose: Write-only configuration bank plus the PWM, gate and limit logic it steers.
// Assumes: Host parallel pins are asynchronous to core_clk_i; command inputs are synchronous.
// Notes: Reads only advance the address; no data is returned.
`timescale 1ns/100ps
module motor_drive_write_config_bank
	import motor_cfg_pkg::*;
#(
	parameter int SEC_CYCLES = SECOND_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] host_data_i,
	input wire logic host_port_address_strobe_i,
	input wire logic host_wr_strobe_i,
	input wire logic host_rd_strobe_i,
	input wire logic kill_in_i,
	input wire logic brake_request_i,
	input wire logic leg_shunt_select_i,
	input wire logic startup_active_i,
	input wire logic [2:0][PERIOD_W-1:0] duty_i,
	input wire logic signed [15:0] current_sample_i,
	input wire logic signed [15:0] vq_cmd_i,
	input wire logic signed [15:0] vd_cmd_i,
	input wire logic signed [15:0] speed_ctrl_out_i,
	output logic [2:0] gate_upper_o,
	output logic [2:0] gate_lower_o,
	output logic brake_out_o,
	output logic sync_out_o,
	output logic driver_shutdown_out_o,
	output logic motor_run_o,
	output logic direction_o,
	output logic offset_measure_start_o,
	output logic modulation_select_o,
	output logic two_phase_variant_o,
	output logic signed [15:0] scaled_current_o,
	output logic signed [15:0] vq_out_o,
	output logic signed [15:0] vd_out_o,
	output logic signed [15:0] torque_ref_o,
	output logic [14:0] current_prop_gain_o,
	output logic [14:0] current_int_gain_o,
	output logic [14:0] speed_prop_gain_o,
	output logic [14:0] speed_int_gain_o,
	output logic [15:0] modulator_scale_o,
	output logic [15:0] speed_scale_o,
	output logic [15:0] speed_setpoint_o,
	output logic [7:0] acceleration_limit_o,
	output logic [7:0] deceleration_limit_o,
	output logic [7:0] minimum_reference_speed_o
);
	// Elaboration check: the one-second tick needs at least one cycle
	if (SEC_CYCLES < 1) begin : g_bad_sec
		$error("SEC_CYCLES must be at least 1");
	end

	typedef struct packed {
		logic [7:0] data_s1;
		logic [7:0] data_s2;
		logic as_s1;
		logic as_s2;
		logic wr_s1;
		logic wr_s2;
		logic wr_s3;
		logic rd_s1;
		logic rd_s2;
		logic rd_s3;
		logic kill_s1;
		logic kill_s2;
		logic [ADDR_W-1:0] addr;
		logic kill_pol;
		logic lower_pol;
		logic upper_pol;
		logic sync_pol;
		logic brake_pol;
		logic shutdown;
		logic [PERIOD_W-1:0] period;
		logic alignment;
		logic variant;
		logic mod_select;
		logic [7:0] dead_time;
		logic [7:0] guard;
		logic [15:0] mod_scale;
		logic [15:0] fb_scale;
		logic run;
		logic direction;
		logic estop;
		logic [15:0] start_lim;
		logic [15:0] cur_kp;
		logic [15:0] cur_ki;
		logic [15:0] vq_lim;
		logic [15:0] vd_lim;
		logic [15:0] spd_kp;
		logic [15:0] spd_ki;
		logic [15:0] motor_lim;
		logic [15:0] regen_lim;
		logic [15:0] spd_scale;
		logic [15:0] spd_set;
		logic [7:0] accel;
		logic [7:0] decel;
		logic [7:0] min_speed;
		logic [7:0] offs_delay;
		logic [PERIOD_W-1:0] cnt;
		logic down;
		logic [PERIOD_W-1:0] per_act;
		logic [2:0][PERIOD_W-1:0] duty_act;
		logic [2:0] raw;
		logic [2:0][7:0] dead;
		logic [2:0] gate_u;
		logic [2:0] gate_l;
		logic sync_out;
		logic brake_out;
		logic timing;
		logic [31:0] sec_cyc;
		logic [7:0] sec_left;
		logic offs_start;
		logic [15:0] scaled_cur;
		logic [15:0] vq_out;
		logic [15:0] vd_out;
		logic [15:0] torque;
		logic run_out;
		logic variant_out;
	} state_t;

	state_t state_q;
	state_t state_d;

	// Shared saturation for every limit stage
	function automatic logic signed [15:0] clamp16(input logic signed [15:0] v,
			input logic signed [15:0] lo, input logic signed [15:0] hi);
		logic signed [15:0] r;
		r = v;
		if (v > hi) begin
			r = hi;
		end else if (v < lo) begin
			r = lo;
		end
		return r;
	endfunction

	// Register write, PWM carrier, gate drive and limit datapath
	always_comb begin
		logic wr_evt;
		logic rd_evt;
		logic [7:0] d;
		logic period_start;
		logic half_turn;
		logic kill_on;
		logic en;
		logic [PERIOD_W-1:0] dmin;
		logic [PERIOD_W-1:0] dmax;
		logic [PERIOD_W-1:0] guard_c;
		logic [PERIOD_W-1:0] eff;
		logic [2:0] raw_n;
		logic [30:0] prod;
		logic signed [15:0] tq;
		wr_evt = state_q.wr_s2 & ~state_q.wr_s3;
		rd_evt = state_q.rd_s2 & ~state_q.rd_s3;
		d = state_q.data_s2;
		period_start = state_q.down && (state_q.cnt == '0);
		half_turn = !state_q.down && (state_q.cnt == state_q.per_act);
		kill_on = (state_q.kill_s2 == state_q.kill_pol); // [RULE_09]
		en = state_q.run & ~state_q.estop & ~kill_on; // [RULE_16] [RULE_17]
		dmin = duty_i[0];
		dmax = duty_i[0];
		guard_c = PERIOD_W'((32'(state_q.guard) * GUARD_UNIT_NS + CLK_PERIOD_NS - 1)
			/ CLK_PERIOD_NS);
		eff = '0;
		raw_n = '0;
		prod = '0;
		tq = '0;
		state_d = state_q;

		// Pin synchronisers; the second stage feeds logic, and the write and read strobes keep a third stage for edge detection
		state_d.data_s1 = host_data_i;
		state_d.data_s2 = state_q.data_s1;
		state_d.as_s1 = host_port_address_strobe_i;
		state_d.as_s2 = state_q.as_s1;
		state_d.wr_s1 = host_wr_strobe_i;
		state_d.wr_s2 = state_q.wr_s1;
		state_d.wr_s3 = state_q.wr_s2;
		state_d.rd_s1 = host_rd_strobe_i;
		state_d.rd_s2 = state_q.rd_s1;
		state_d.rd_s3 = state_q.rd_s2;
		state_d.kill_s1 = kill_in_i;
		state_d.kill_s2 = state_q.kill_s1;

		// Address byte loads the pointer; each data byte advances it
		if (wr_evt && state_q.as_s2) begin
			state_d.addr = d[ADDR_W-1:0];
		end else if ((wr_evt || rd_evt) && !state_q.as_s2) begin
			state_d.addr = state_q.addr + 7'h01; // [RULE_23]
		end

		// Byte writes; unmapped offsets are dropped, nothing reads back
		if (wr_evt && !state_q.as_s2) begin
			case (state_q.addr) // [RULE_24]
				OFS_GATE_CTRL: begin
					state_d.kill_pol = d[BIT_KILL_POL];
					state_d.lower_pol = d[BIT_LOWER_POL];
					state_d.upper_pol = d[BIT_UPPER_POL];
					state_d.sync_pol = d[BIT_SYNC_POL];
					state_d.brake_pol = d[BIT_BRAKE_POL];
					state_d.shutdown = d[BIT_SHUTDOWN];
				end
				OFS_PERIOD_LO: state_d.period[7:0] = d;
				OFS_MODE_PERIOD_HI: begin
					state_d.period[PERIOD_W-1:8] = d[PERIOD_W-9:0];
					state_d.alignment = d[BIT_ALIGNMENT];
					state_d.variant = d[BIT_TWO_PH_VARIANT];
					state_d.mod_select = d[BIT_MOD_SELECT];
				end
				OFS_DEAD_TIME: state_d.dead_time = d;
				OFS_FB_SCALE_LO: state_d.fb_scale[7:0] = d;
				OFS_FB_SCALE_HI: state_d.fb_scale[15:8] = d;
				OFS_RUN_CMD: begin
					state_d.estop = d[BIT_ESTOP];
					state_d.run = d[BIT_RUN];
					state_d.direction = d[BIT_DIRECTION]; // [RULE_15]
				end
				OFS_START_LIM_LO: state_d.start_lim[7:0] = d;
				OFS_START_LIM_HI: state_d.start_lim[15:8] = d;
				OFS_CUR_KP_LO: state_d.cur_kp[7:0] = d;
				OFS_CUR_KP_HI: state_d.cur_kp[15:8] = d;
				OFS_CUR_KI_LO: state_d.cur_ki[7:0] = d;
				OFS_CUR_KI_HI: state_d.cur_ki[15:8] = d;
				OFS_VQ_LIM_LO: state_d.vq_lim[7:0] = d;
				OFS_VQ_LIM_HI: state_d.vq_lim[15:8] = d;
				OFS_VD_LIM_LO: state_d.vd_lim[7:0] = d;
				OFS_VD_LIM_HI: state_d.vd_lim[15:8] = d;
				OFS_SPD_KP_LO: state_d.spd_kp[7:0] = d;
				OFS_SPD_KP_HI: state_d.spd_kp[15:8] = d;
				OFS_SPD_KI_LO: state_d.spd_ki[7:0] = d;
				OFS_SPD_KI_HI: state_d.spd_ki[15:8] = d;
				OFS_MOTOR_LIM_LO: state_d.motor_lim[7:0] = d;
				OFS_MOTOR_LIM_HI: state_d.motor_lim[15:8] = d;
				OFS_REGEN_LIM_LO: state_d.regen_lim[7:0] = d;
				OFS_REGEN_LIM_HI: state_d.regen_lim[15:8] = d;
				OFS_SPD_SCALE_LO: state_d.spd_scale[7:0] = d;
				OFS_SPD_SCALE_HI: state_d.spd_scale[15:8] = d;
				OFS_SPD_SET_LO: state_d.spd_set[7:0] = d;
				OFS_SPD_SET_HI: state_d.spd_set[15:8] = d;
				OFS_ACCEL: state_d.accel = d;
				OFS_DECEL: state_d.decel = d;
				OFS_MOD_SCALE_LO: state_d.mod_scale[7:0] = d;
				OFS_MOD_SCALE_HI: state_d.mod_scale[15:8] = d;
				OFS_GUARD: state_d.guard = d;
				OFS_MIN_SPEED: state_d.min_speed = d;
				OFS_OFFSET_DELAY: state_d.offs_delay = d;
				default: ;
			endcase
		end

		// Triangle carrier: P+1 cycles up, P+1 down, period latched at the valley
		if (!state_q.down) begin
			if (half_turn) begin
				state_d.down = 1'b1; // [RULE_01]
			end else begin
				state_d.cnt = state_q.cnt + 1'b1;
			end
		end else if (period_start) begin
			state_d.down = 1'b0;
			state_d.per_act = state_q.period; // [RULE_01]
		end else begin
			state_d.cnt = state_q.cnt - 1'b1;
		end

		// Flat-top offsets for two-phase mode use the extreme duties
		for (int i = 1; i < 3; i++) begin
			if (duty_i[i] < dmin) dmin = duty_i[i];
			if (duty_i[i] > dmax) dmax = duty_i[i];
		end
		if (duty_i[0] < dmin) dmin = duty_i[0];
		if (duty_i[0] > dmax) dmax = duty_i[0];

		// Symmetrical updates duty once per period, asymmetrical at both turns
		if (period_start || (half_turn && !state_q.alignment)) begin // [RULE_02]
			for (int i = 0; i < 3; i++) begin
				eff = duty_i[i];
				if (state_q.mod_select) begin // [RULE_03]
					if (!state_q.variant) begin
						eff = duty_i[i] - dmin; // [RULE_04]
					end else begin
						eff = duty_i[i] + (state_q.period + 1'b1 - dmax); // [RULE_04]
					end
				end else if (eff != '0 && eff < guard_c) begin
					eff = guard_c; // [RULE_11]
				end
				state_d.duty_act[i] = eff;
			end
		end

		// Dead time: after any change of demand both switches stay off
		for (int i = 0; i < 3; i++) begin
			raw_n[i] = state_d.cnt < state_q.duty_act[i];
			if (raw_n[i] != state_q.raw[i]) begin
				state_d.dead[i] = state_q.dead_time; // [RULE_05]
			end else if (state_q.dead[i] != 8'h00) begin
				state_d.dead[i] = state_q.dead[i] - 8'h01;
			end
			state_d.gate_u[i] = (en && raw_n[i] && state_d.dead[i] == 8'h00)
				? state_q.upper_pol : ~state_q.upper_pol; // [RULE_06]
			state_d.gate_l[i] = (en && !raw_n[i] && state_d.dead[i] == 8'h00)
				? state_q.lower_pol : ~state_q.lower_pol; // [RULE_06]
		end
		state_d.raw = raw_n;
		// Registered so the run and variant pins carry no gate after the flop
		state_d.run_out = state_q.run & ~state_q.estop; // [RULE_17]
		state_d.variant_out = state_q.variant & state_q.mod_select; // [RULE_04]
		state_d.sync_out = period_start ? state_q.sync_pol : ~state_q.sync_pol; // [RULE_08]
		state_d.brake_out = brake_request_i ? state_q.brake_pol : ~state_q.brake_pol; // [RULE_07]

		// Offset re-measure delay, counted in whole seconds after a stop
		state_d.offs_start = 1'b0;
		if (state_q.run && !state_d.run && leg_shunt_select_i) begin
			state_d.timing = 1'b1; // [RULE_14]
			state_d.sec_left = state_d.offs_delay;
			state_d.sec_cyc = '0;
		end else if (state_q.timing) begin
			if (state_q.sec_left == 8'h00) begin
				state_d.timing = 1'b0;
				state_d.offs_start = 1'b1; // [RULE_14]
			end else if (state_q.sec_cyc == 32'(SEC_CYCLES - 1)) begin
				state_d.sec_cyc = '0;
				state_d.sec_left = state_q.sec_left - 8'h01;
			end else begin
				state_d.sec_cyc = state_q.sec_cyc + 32'h00000001;
			end
		end

		// Feedback scaling and the limit stages
		prod = 31'(32'($signed(current_sample_i)) * 32'($signed(state_q.fb_scale[14:0])));
		state_d.scaled_cur = prod[FEEDBACK_FRAC_BITS+15:FEEDBACK_FRAC_BITS]; // [RULE_13]
		state_d.vq_out = clamp16(vq_cmd_i, -$signed(state_q.vq_lim),
			$signed(state_q.vq_lim)); // [RULE_19]
		state_d.vd_out = clamp16(vd_cmd_i, -$signed(state_q.vd_lim),
			$signed(state_q.vd_lim)); // [RULE_19]
		tq = clamp16(speed_ctrl_out_i, $signed(state_q.regen_lim),
			$signed(state_q.motor_lim)); // [RULE_21]
		if (startup_active_i) begin
			tq = clamp16(tq, -$signed(state_q.start_lim), $signed(state_q.start_lim)); // [RULE_22]
		end
		state_d.torque = tq;
	end

	// Single state register; gate outputs rest at the inactive level of polarity 0
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= '0;
			state_q.gate_u <= 3'h7;
			state_q.gate_l <= 3'h7;
			state_q.sync_out <= 1'b1;
			state_q.brake_out <= 1'b1;
			state_q.fb_scale <= RESET_WORD;
			state_q.dead_time <= RESET_BYTE;
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs straight from the state register
	assign gate_upper_o = state_q.gate_u;
	assign gate_lower_o = state_q.gate_l;
	assign brake_out_o = state_q.brake_out;
	assign sync_out_o = state_q.sync_out;
	assign driver_shutdown_out_o = state_q.shutdown; // [RULE_10]
	assign motor_run_o = state_q.run_out; // [RULE_17]
	assign direction_o = state_q.direction;
	assign offset_measure_start_o = state_q.offs_start;
	assign modulation_select_o = state_q.mod_select;
	assign two_phase_variant_o = state_q.variant_out; // [RULE_04]
	assign scaled_current_o = state_q.scaled_cur;
	assign vq_out_o = state_q.vq_out;
	assign vd_out_o = state_q.vd_out;
	assign torque_ref_o = state_q.torque;
	assign current_prop_gain_o = state_q.cur_kp[14:0]; // [RULE_18]
	assign current_int_gain_o = state_q.cur_ki[14:0]; // [RULE_18]
	assign speed_prop_gain_o = state_q.spd_kp[14:0]; // [RULE_20]
	assign speed_int_gain_o = state_q.spd_ki[14:0]; // [RULE_20]
	assign modulator_scale_o = state_q.mod_scale; // [RULE_12]
	assign speed_scale_o = state_q.spd_scale;
	assign speed_setpoint_o = state_q.spd_set;
	assign acceleration_limit_o = state_q.accel;
	assign deceleration_limit_o = state_q.decel;
	assign minimum_reference_speed_o = state_q.min_speed;

	// Helper: cycles since the last sync pulse, for the period check
	logic [15:0] gap_q;
	logic seen_q;
	logic sync_evt;
	logic wr_data_evt;
	assign sync_evt = state_q.down && (state_q.cnt == '0);
	assign wr_data_evt = state_q.wr_s2 && !state_q.wr_s3 && !state_q.as_s2;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gap_q <= 16'h0000;
			seen_q <= 1'b0;
		end else begin
			gap_q <= sync_evt ? 16'h0001 : gap_q + 16'h0001;
			seen_q <= seen_q | sync_evt;
		end
	end

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	carrier_period_a: assert property ( // [RULE_01]
		sync_evt && seen_q && $stable(state_q.per_act)
		|-> gap_q == 16'(2 * (32'(state_q.per_act) + 1)))
		else $error("carrier period differs from programmed value");
	no_overlap_a: assert property ( // [RULE_05]
		!(gate_upper_o[0] == $past(state_q.upper_pol)
		&& gate_lower_o[0] == $past(state_q.lower_pol)))
		else $error("upper and lower gate on together");
	dead_gap_a: assert property ( // [RULE_05]
		state_d.raw[0] != state_q.raw[0] && state_q.dead_time != 8'h00
		|=> gate_upper_o[0] != $past(state_q.upper_pol)
		&& gate_lower_o[0] != $past(state_q.lower_pol))
		else $error("no dead time after transition");
	kill_gates_a: assert property ( // [RULE_09]
		state_q.kill_s2 == state_q.kill_pol
		|=> gate_upper_o == {3{~$past(state_q.upper_pol)}})
		else $error("gates active during kill");
	estop_coast_a: assert property ( // [RULE_17]
		state_q.estop |=> gate_lower_o == {3{~$past(state_q.lower_pol)}}
		&& !motor_run_o)
		else $error("gates active during emergency stop");
	sync_pulse_a: assert property ( // [RULE_08]
		sync_evt |=> sync_out_o == $past(state_q.sync_pol)
		##1 sync_out_o != $past(state_q.sync_pol))
		else $error("sync pulse wrong level or length");
	addr_incr_a: assert property ( // [RULE_23]
		wr_data_evt |=> state_q.addr == $past(state_q.addr) + 7'h01)
		else $error("address not advanced after data byte");
	shutdown_write_a: assert property ( // [RULE_10]
		wr_data_evt && state_q.addr == OFS_GATE_CTRL
		|=> driver_shutdown_out_o == $past(state_q.data_s2[BIT_SHUTDOWN]))
		else $error("shutdown output not following write");
	vq_clamp_a: assert property ( // [RULE_19]
		!state_q.vq_lim[15]
		|=> vq_out_o <= $signed($past(state_q.vq_lim))
		&& vq_out_o >= -$signed($past(state_q.vq_lim)))
		else $error("quadrature voltage beyond limit");

	run_start_c: cover property (!motor_run_o ##1 motor_run_o);
	offset_start_c: cover property (offset_measure_start_o);
	two_phase_c: cover property (modulation_select_o && sync_evt);
	kill_c: cover property (state_q.kill_s2 == state_q.kill_pol && state_q.run);
endmodule

// ===== verification/host_model.sv
// Purpose: Host side of the byte-wide register port.
// Assumes: Data and strobes held 4 clocks, above the 3 the sync stages need.
// Notes: Released data bus shows the inverse of the last byte.
`timescale 1ns/100ps
module host_model (
	input wire logic clk_i,
	output logic [7:0] data_o,
	output logic addr_o,
	output logic wr_o,
	output logic rd_o
);
	initial begin
		data_o = 8'hFF;
		addr_o = 1'b0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// One byte: address byte when a is set, else data; r picks a read strobe
	task automatic xfer(input logic a, input logic [7:0] d, input logic r);
		@(posedge clk_i);
		data_o <= d;
		addr_o <= a;
		repeat (4) @(posedge clk_i);
		wr_o <= !r;
		rd_o <= r;
		repeat (4) @(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		data_o <= ~d;
		@(posedge clk_i);
	endtask
endmodule

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the motor configuration bank.
// Assumes: SEC_CYCLES shortened to 10 so the offset delay fits the run.
// Notes: Outputs sampled at the falling edge, well after they settle.
`timescale 1ns/100ps
module testbench;
	import motor_cfg_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic brk = 1'b0, leg = 1'b0, stup = 1'b0, kill = 1'b0;
	logic [2:0][PERIOD_W-1:0] duty = '0;
	logic signed [15:0] smp = 16'h0000, vq = 16'h0000, spd = 16'h0000;
	wire [7:0] hd;
	wire ha, hw, hr;
	wire [2:0] gu, gl;
	wire brk_o, sync_o, sd_o, run_o, dir_o, ofs_o, msel, mvar;
	wire [15:0] sc, vqo, vdo, trq, mscl, sset;
	wire [14:0] skp, ski;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	always #12.5 clk = ~clk;
	host_model host_u (.clk_i(clk), .data_o(hd), .addr_o(ha), .wr_o(hw), .rd_o(hr));
	motor_drive_write_config_bank #(.SEC_CYCLES(10)) dut_u (
		.core_clk_i(clk), .reset_n_i(rst_n), .host_data_i(hd),
		.host_port_address_strobe_i(ha), .host_wr_strobe_i(hw), .host_rd_strobe_i(hr),
		.kill_in_i(kill), .brake_request_i(brk), .leg_shunt_select_i(leg),
		.startup_active_i(stup), .duty_i(duty), .current_sample_i(smp), .vq_cmd_i(vq),
		.vd_cmd_i(vq), .speed_ctrl_out_i(spd), .gate_upper_o(gu), .gate_lower_o(gl),
		.brake_out_o(brk_o), .sync_out_o(sync_o), .driver_shutdown_out_o(sd_o),
		.motor_run_o(run_o), .direction_o(dir_o), .offset_measure_start_o(ofs_o),
		.modulation_select_o(msel), .two_phase_variant_o(mvar), .scaled_current_o(sc),
		.vq_out_o(vqo), .vd_out_o(vdo), .torque_ref_o(trq), .current_prop_gain_o(),
		.current_int_gain_o(), .speed_prop_gain_o(skp), .speed_int_gain_o(ski),
		.modulator_scale_o(mscl), .speed_scale_o(), .speed_setpoint_o(sset),
		.acceleration_limit_o(), .deceleration_limit_o(), .minimum_reference_speed_o());
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// Address byte, then a burst of data bytes at rising offsets
	task automatic put(input logic [6:0] a, input logic [7:0] b[$]);
		host_u.xfer(1'b1, {1'b0, a}, 1'b0);
		foreach (b[i]) host_u.xfer(1'b0, b[i], 1'b0);
		repeat (3) @(negedge clk);
	endtask
	// Settle, then count upper gate 0 on-cycles over one 20-clock carrier
	task automatic on_cnt(input string n, input int e);
		int k = 0;
		repeat (20) @(negedge clk);
		repeat (20) begin
			@(negedge clk);
			k += gu[0];
		end
		chk(n, e[15:0], k[15:0]);
	endtask
	task automatic t_reset;
		chk("gate_upper", 16'h7, gu);
		chk("shutdown", 16'h0, sd_o);
		chk("run", 16'h0, run_o);
	endtask
	task automatic t_pol;
		put(OFS_GATE_CTRL, '{8'hB6});
		chk("gate_lower", 16'h0, gl);
		chk("shutdown", 16'h1, sd_o);
		chk("brake_idle", 16'h0, brk_o);
		@(posedge clk) brk <= 1'b1;
		repeat (3) @(negedge clk);
		chk("brake_on", 16'h1, brk_o);
	endtask
	// Run, stop, emergency stop and direction; the last stop arms the offset timer
	task automatic t_run;
		logic [7:0] cmd[4] = '{8'h03, 8'h07, 8'h02, 8'h00};
		int c;
		put(OFS_OFFSET_DELAY, '{8'h05});
		for (int i = 0; i < 4; i++) begin
			if (i == 3) @(posedge clk) leg <= 1'b1;
			put(OFS_RUN_CMD, '{cmd[i]});
			chk("run", cmd[i][1] & !cmd[i][2], run_o);
			chk("direction", cmd[i][0], dir_o);
		end
		c = 0;
		while (ofs_o !== 1'b1 && c < 100) begin
			@(negedge clk);
			c++;
		end
		chk("offset_delay", 16'h1, c > 30 && c < 45);
	endtask
	// Burst fill, a read that only steps the address, and an unmapped byte
	task automatic t_burst;
		put(OFS_SPD_KP_LO, '{8'h34, 8'h92, 8'h78, 8'hD6});
		chk("speed_kp", 16'h1234, skp);
		chk("speed_ki", 16'h5678, ski);
		host_u.xfer(1'b1, {1'b0, OFS_SPD_SET_LO}, 1'b0);
		host_u.xfer(1'b0, 8'hFF, 1'b1);
		host_u.xfer(1'b0, 8'hA5, 1'b0);
		put(7'h43, '{8'hEE, 8'h1B, 8'h00});
		chk("setpoint", 16'hA500, sset);
		chk("mod_scale", 16'h001B, mscl);
	endtask
	task automatic t_limits;
		put(OFS_VQ_LIM_LO, '{8'h00, 8'h01});
		put(OFS_VD_LIM_LO, '{8'h80, 8'h00});
		put(OFS_MOTOR_LIM_LO, '{8'hFF, 8'h0F, 8'h01, 8'hF0});
		put(OFS_START_LIM_LO, '{8'h00, 8'h01});
		put(OFS_FB_SCALE_LO, '{8'h00, 8'h08});
		@(posedge clk) begin
			vq <= 16'h0300;
			spd <= 16'h2000;
			smp <= 16'h0123;
		end
		repeat (3) @(negedge clk);
		chk("vq_hi", 16'h0100, vqo);
		chk("vd", 16'h0080, vdo);
		chk("torque_hi", 16'h0FFF, trq);
		chk("current", 16'h0246, sc);
		@(posedge clk) begin
			vq <= 16'hFD00;
			spd <= 16'h8000;
			smp <= 16'hFF00;
		end
		repeat (3) @(negedge clk);
		chk("vq_lo", 16'hFF00, vqo);
		chk("vd_lo", 16'hFF80, vdo);
		chk("torque_lo", 16'hF001, trq);
		chk("current_neg", 16'hFE00, sc);
		@(posedge clk) begin
			stup <= 1'b1;
			spd <= 16'h2000;
		end
		repeat (3) @(negedge clk);
		chk("startup", 16'h0100, trq);
	endtask
	// Carrier of period value 9 spans 20 clocks between sync pulses
	task automatic t_pwm;
		int n;
		put(OFS_GATE_CTRL, '{8'hBE});
		put(OFS_PERIOD_LO, '{8'h09, 8'h40});
		chk("variant_3ph", 16'h0, mvar);
		chk("mode_3ph", 16'h0, msel);
		do @(negedge clk); while (sync_o !== 1'b1);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sync_o !== 1'b1);
		chk("sync_gap", 16'd20, n[15:0]);
		// Duty 2 of period 9: guard band of 4 units lifts it to 5, dead time trims 2
		@(posedge clk) duty <= {3{13'd2}};
		put(OFS_RUN_CMD, '{8'h03});
		on_cnt("on_3ph", 4);
		put(OFS_GUARD, '{8'h04});
		on_cnt("on_guard", 10);
		put(OFS_DEAD_TIME, '{8'h02});
		on_cnt("on_dead", 8);
		@(posedge clk) kill <= 1'b1;
		on_cnt("on_kill", 0);
		put(OFS_MODE_PERIOD_HI, '{8'hC0});
		chk("mode_2ph", 16'h1, msel);
		chk("variant_2ph", 16'h1, mvar);
	endtask
	task automatic report_and_stop;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Hang guard, far above the thousand or so cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(negedge clk);
		t_reset();
		t_pol();
		t_run();
		t_burst();
		t_limits();
		t_pwm();
		report_and_stop();
	end
endmodule
